/* File: src/sfpi_defines.svh */
// Purpose: constants of the serial flash pin front end
// Assumes: included by bare name from the top file
// Notes:   definitions only
`ifndef SFPI_DEFINES_SVH
`define SFPI_DEFINES_SVH

// --------------------------------------------------------------
// widths and depths
// --------------------------------------------------------------
`define SFPI_BYTE_W      8
`define SFPI_FIFO_DEPTH  8
`define SFPI_BITS_BYTE   4'h8

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define SFPI_CNT_RST     4'h0
`define SFPI_BYTE_RST    8'h00
`define SFPI_BITS_RST    4'h0

`endif

/* File: src/sfpi_pkg.sv */
// Purpose: shared types of the serial flash pin front end
// Assumes: nothing
// Notes:   constants live in sfpi_defines.svh
package sfpi_pkg;

  // --------------------------------------------------------------
  // transfer width of the current instruction
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    sfpi_w_single,
    sfpi_w_dual,
    sfpi_w_quad
  } sfpi_width_type;

endpackage : sfpi_pkg

/* File: src/sfpi_top.sv */
// Purpose: pin front end of a serial flash slave interface
// Assumes: spi pins are asynchronous to ref_clk_i, sampled 2-FF
// Notes:   spi clock must be well below a quarter of ref_clk_i
`timescale 1ns/10ps
`include "sfpi_defines.svh"

// --------------------------------------------------------------
// fifo of received bytes
// --------------------------------------------------------------
module sfpi_fifo #(
  parameter int WIDTH = `SFPI_BYTE_W,
  parameter int DEPTH = `SFPI_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];   // storage words
  logic [AW:0]      wr_ptr_r;        // write pointer, wrap bit on top
  logic [AW:0]      rd_ptr_r;        // read pointer, wrap bit on top
  logic             push;            // word accepted
  logic             pop;             // word handed out
  logic             full;            // no room left
  logic             empty;           // nothing stored

  // full when pointers differ only in the wrap bit
  assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                 (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign push  = in_valid_i && !full;
  assign pop   = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

  // storage write, no reset needed on the data
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  // pointer update
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end
endmodule : sfpi_fifo

// --------------------------------------------------------------
// pin front end top
// --------------------------------------------------------------
module sfpi_top (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // spi pins from the host
  input  wire logic                 spi_clk_i,
  input  wire logic                 spi_cs_n_i,
  // bidirectional data lines
  input  wire logic                 bidir_line_zero_i,
  output logic                      bidir_line_zero_o,
  output logic                      bidir_line_zero_oe_n_o,
  input  wire logic                 bidir_line_one_i,
  output logic                      bidir_line_one_o,
  output logic                      bidir_line_one_oe_n_o,
  input  wire logic                 bidir_line_two_i,
  output logic                      bidir_line_two_o,
  output logic                      bidir_line_two_oe_n_o,
  input  wire logic                 bidir_line_three_i,
  output logic                      bidir_line_three_o,
  output logic                      bidir_line_three_oe_n_o,
  // instruction context from the core
  input  sfpi_pkg::sfpi_width_type  width_i,
  input  wire logic                 data_out_phase_i,
  input  wire logic                 busy_i,
  // status bits from the core
  input  wire logic                 status_lock_upper_bit_i,
  input  wire logic                 status_lock_lower_bit_i,
  input  wire logic                 quad_enable_bit_i,
  // received bytes toward the core
  output logic [`SFPI_BYTE_W-1:0]   rx_data_o,
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  // read data from the core
  input  wire logic [`SFPI_BYTE_W-1:0] tx_data_i,
  output logic                      tx_take_o,
  // status toward the core
  output logic                      selected_o,
  output logic                      standby_o,
  output logic                      frame_start_o,
  output logic                      paused_o,
  output logic                      quad_refused_o,
  output logic                      rx_overrun_o,
  output logic                      status_write_blocked_o,
  output logic                      array_protect_locked_o
);
  import sfpi_pkg::*;

  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------
  // bits moved per clock edge for a width
  function automatic logic [3:0] step_of(input sfpi_width_type w);
    logic [3:0] s;
    s = 4'h1;
    if (w == sfpi_w_dual) begin
      s = 4'h2;
    end else if (w == sfpi_w_quad) begin
      s = 4'h4;
    end
    return s;
  endfunction : step_of

  // lines driven for a width, bit n is line n
  function automatic logic [3:0] mask_of(input sfpi_width_type w);
    logic [3:0] m;
    m = 4'h2;
    if (w == sfpi_w_dual) begin
      m = 4'h3;
    end else if (w == sfpi_w_quad) begin
      m = 4'hF;
    end
    return m;
  endfunction : mask_of

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [5:0] sync1_r;      // first stage, read by sync2_r only
  logic [5:0] sync2_r;      // second stage, safe to use
  logic       clk_prev_r;   // spi clock one cycle back
  logic       cs_prev_r;    // select one cycle back
  logic [5:0] pins;         // raw pins in sync order

  assign pins = {spi_clk_i, spi_cs_n_i, bidir_line_three_i,
                 bidir_line_two_i, bidir_line_one_i, bidir_line_zero_i};

  // two flops on every pin, then edge history
  // no reset: the chain tracks the pins through reset, so a select
  // held low across reset gives no false fall and does not arm
  always_ff @(posedge ref_clk_i) begin
    sync1_r    <= pins;
    sync2_r    <= sync1_r;
    clk_prev_r <= sync2_r[5];
    cs_prev_r  <= sync2_r[4];
  end

  // --------------------------------------------------------------
  // decoded pin state
  // --------------------------------------------------------------
  wire        clk_now  = sync2_r[5];            // spi clock level
  wire        cs_now   = sync2_r[4];            // select, active low
  wire [3:0]  line_in  = sync2_r[3:0];          // data lines
  wire        clk_rise = clk_now && !clk_prev_r;
  wire        clk_fall = !clk_now && clk_prev_r;
  wire        cs_fall  = !cs_now && cs_prev_r;

  logic armed_r;    // a select fall was seen since reset
  logic paused_r;   // pause condition in force

  wire quad_bad = (width_i == sfpi_w_quad) && !quad_enable_bit_i;
  wire sfpi_width_type eff_w = quad_bad ? sfpi_w_single : width_i;
  wire        quad_on = (eff_w == sfpi_w_quad);
  wire [3:0]  step    = step_of(eff_w);

  wire selected = armed_r && !cs_now;
  wire live     = selected && !paused_r;

  // protect pin unused under quad enable
  wire wp_low   = !quad_enable_bit_i && !line_in[2];
  wire hold_on  = !quad_on && !quad_enable_bit_i;
  wire hold_low = !line_in[3];

  wire locked = wp_low && !status_lock_upper_bit_i &&
                status_lock_lower_bit_i;

  // --------------------------------------------------------------
  // select tracking and pause
  // --------------------------------------------------------------
  logic paused_nxt;   // next pause state

  always_comb begin
    paused_nxt = paused_r;
    if (!selected || !hold_on) begin
      paused_nxt = 1'b0;
    end else if (!clk_now) begin
      paused_nxt = hold_low;
    end
  end

  // arm on first select fall, hold pause state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      armed_r  <= 1'b0;
      paused_r <= 1'b0;
    end else begin
      armed_r  <= armed_r || cs_fall;
      paused_r <= paused_nxt;
    end
  end

  // --------------------------------------------------------------
  // receive shifter
  // --------------------------------------------------------------
  logic [7:0] rx_sh_r;       // bits gathered so far
  logic [3:0] rx_cnt_r;      // bits gathered count
  logic       push_r;        // byte ready for the fifo
  logic [7:0] push_data_r;   // byte handed to the fifo
  logic       overrun_r;     // byte lost to a full fifo
  logic       fifo_ready;    // fifo has room

  // new shift value for each width, msb first
  wire [7:0] rx_shift =
    quad_on ? {rx_sh_r[3:0], line_in} :
    (eff_w == sfpi_w_dual) ? {rx_sh_r[5:0], line_in[1:0]} :
    {rx_sh_r[6:0], line_in[0]};
  wire [3:0] rx_cnt_add = rx_cnt_r + step;
  wire rx_take  = live && clk_rise && !data_out_phase_i;
  wire rx_done  = rx_take && (rx_cnt_add == `SFPI_BITS_BYTE);

  // gather bits, restart on every deselect
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !selected) begin
      rx_sh_r  <= `SFPI_BYTE_RST;
      rx_cnt_r <= `SFPI_CNT_RST;
    end else if (rx_take) begin
      rx_sh_r  <= rx_shift;
      rx_cnt_r <= rx_done ? `SFPI_CNT_RST : rx_cnt_add;
    end
  end

  // fifo push stage and overrun flag, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      push_r      <= 1'b0;
      push_data_r <= `SFPI_BYTE_RST;
      overrun_r   <= 1'b0;
    end else begin
      push_r <= rx_done;
      if (rx_done) begin
        push_data_r <= rx_shift;
      end
      if (push_r && !fifo_ready) begin
        overrun_r <= 1'b1;
      end else if (cs_fall) begin
        overrun_r <= 1'b0;
      end
    end
  end

  // byte queue toward the core
  sfpi_fifo #(
    .WIDTH (`SFPI_BYTE_W),
    .DEPTH (`SFPI_FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_r),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_data_r),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  // --------------------------------------------------------------
  // transmit shifter
  // --------------------------------------------------------------
  logic [7:0] tx_sh_r;     // remaining bits of the byte
  logic [3:0] tx_cnt_r;    // bits already sent of the byte
  logic [3:0] out_bits_r;  // levels on the four lines
  logic       drive_r;     // a data bit has been launched
  logic       take_r;      // byte taken from the core

  // first launch is a fall in either mode
  wire       tx_step = live && clk_fall && data_out_phase_i;
  wire [7:0] tx_cur  = (tx_cnt_r == `SFPI_CNT_RST) ? tx_data_i : tx_sh_r;
  wire [3:0] tx_add  = tx_cnt_r + step;
  // line levels: quad 7..4, dual 7..6 on lines 1..0, single 7 on 1
  wire [3:0] tx_bits =
    quad_on ? tx_cur[7:4] :
    (eff_w == sfpi_w_dual) ? {2'b00, tx_cur[7:6]} :
    {2'b00, tx_cur[7], 1'b0};
  wire [7:0] tx_next = tx_cur << step;

  // shift out, restart on every deselect
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !selected) begin
      tx_sh_r    <= `SFPI_BYTE_RST;
      tx_cnt_r   <= `SFPI_CNT_RST;
      out_bits_r <= `SFPI_BITS_RST;
    end else if (tx_step) begin
      tx_sh_r    <= tx_next;
      tx_cnt_r   <= (tx_add == `SFPI_BITS_BYTE) ? `SFPI_CNT_RST : tx_add;
      out_bits_r <= tx_bits;
    end
  end

  // drive window and byte take pulse
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      drive_r <= 1'b0;
      take_r  <= 1'b0;
    end else begin
      take_r <= tx_step && (tx_cnt_r == `SFPI_CNT_RST);
      if (!selected || !data_out_phase_i) begin
        drive_r <= 1'b0;
      end else if (tx_step) begin
        drive_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // line drivers
  // --------------------------------------------------------------
  wire [3:0] line_out;   // levels per line
  wire [3:0] line_oe_n;  // enables per line, low drives
  wire [3:0] line_mask;  // lines used by the current width

  assign line_mask = mask_of(eff_w);

  // drive only in read data phase
  generate
    for (genvar g = 0; g < 4; g++) begin : g_line
      assign line_out[g]  = out_bits_r[g];
      assign line_oe_n[g] = !(drive_r && live && data_out_phase_i &&
                              line_mask[g]);
    end
  endgenerate

  assign bidir_line_zero_o       = line_out[0];
  assign bidir_line_zero_oe_n_o  = line_oe_n[0];
  assign bidir_line_one_o        = line_out[1];
  assign bidir_line_one_oe_n_o   = line_oe_n[1];
  assign bidir_line_two_o        = line_out[2];
  assign bidir_line_two_oe_n_o   = line_oe_n[2];
  assign bidir_line_three_o      = line_out[3];
  assign bidir_line_three_oe_n_o = line_oe_n[3];

  // --------------------------------------------------------------
  // status outputs
  // --------------------------------------------------------------
  // standby when idle and deselected
  assign standby_o              = !selected && !busy_i;
  assign selected_o             = selected;
  assign frame_start_o          = cs_fall;
  assign paused_o               = paused_r;
  assign quad_refused_o         = quad_bad;
  assign rx_overrun_o           = overrun_r;
  assign tx_take_o              = take_r;
  assign status_write_blocked_o = locked;
  assign array_protect_locked_o = locked;
endmodule : sfpi_top

/* File: bench/sfpi_host.sv */
// Purpose: host spi controller model driving clock, select and lines
// Assumes: link period 160 ns, modes 0 and 3
// Notes:   timing is free running, unrelated to the ref clock
`timescale 1ns/10ps
module sfpi_host (
  // pins toward the device
  output logic            spi_clk_o,
  output logic            spi_cs_n_o,
  output logic [3:0]      dat_o,
  output logic [3:0]      dat_oe_n_o,
  // resolved line levels
  input  wire logic [3:0] line_i
);
  localparam time HALF = 80ns; // half link period
  logic cpol;                  // 1 selects clock mode 3
  logic wp_n;                  // level asked of the protect pin
  logic hold_n;                // level asked of the pause pin

  // idle: deselected, lines released
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    cpol = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
    rel();
  end

  task automatic rel();
    dat_o = 4'h0;
    dat_oe_n_o = {hold_n, wp_n, 2'h3};
  endtask : rel

  task automatic set_hold(input logic v);
    hold_n = v;
    dat_o[3] = 1'b0;
    dat_oe_n_o[3] = v;
  endtask : set_hold

  // select falls before bits, idle level per mode
  task automatic frame_begin();
    spi_clk_o = cpol;
    #HALF spi_cs_n_o = 1'b0;
    #HALF;
  endtask : frame_begin

  task automatic frame_end();
    spi_clk_o = cpol;
    #HALF spi_cs_n_o = 1'b1;
    rel();
    #HALF;
  endtask : frame_end

  // drive after fall, sample at rise, msb first
  task automatic xfer(input int nl, input bit rd, input logic [7:0] b,
                      output logic [7:0] r);
    logic [3:0] g;
    r = 8'h00;
    for (int i = 0; i < 8 / nl; i++) begin
      g = 4'(b >> (8 - nl * (i + 1)));
      spi_clk_o = 1'b0;
      for (int k = 0; k < nl; k++) begin
        dat_o[k] = g[k];
        dat_oe_n_o[k] = rd;
      end
      #HALF spi_clk_o = 1'b1;
      r = (r << nl) | 8'(nl == 1 ? 4'(line_i[1]) : line_i & 4'((1 << nl) - 1));
      #HALF;
    end
    // lines stay as left until the frame ends, no same-step rewrite
  endtask : xfer
endmodule : sfpi_host

/* File: bench/sfpi_monitor.sv */
// Purpose: port assertions of the pin front end
// Assumes: one clock domain, synchronous low reset
// Notes:   bound to sfpi_top at the foot
`timescale 1ns/10ps
module sfpi_chk (
  // clock and reset
  input wire logic                ref_clk_i,
  input wire logic                rst_n_i,
  // pins
  input wire logic                spi_cs_n_i,
  input wire logic                bidir_line_two_i,
  input wire logic                bidir_line_zero_oe_n_o,
  input wire logic                bidir_line_one_oe_n_o,
  input wire logic                bidir_line_two_oe_n_o,
  input wire logic                bidir_line_three_oe_n_o,
  // core side
  input sfpi_pkg::sfpi_width_type width_i,
  input wire logic                data_out_phase_i,
  input wire logic                busy_i,
  input wire logic                status_lock_upper_bit_i,
  input wire logic                status_lock_lower_bit_i,
  input wire logic                quad_enable_bit_i,
  input wire logic                rx_valid_o,
  input wire logic                rx_ready_i,
  input wire logic                tx_take_o,
  input wire logic                standby_o,
  input wire logic                frame_start_o,
  input wire logic                paused_o,
  input wire logic                quad_refused_o,
  input wire logic                status_write_blocked_o,
  input wire logic                array_protect_locked_o
);
  import sfpi_pkg::*;
  wire logic [3:0] oe_n; // all drive enables
  wire logic       lk;   // lock bits in the locking pattern
  assign oe_n = {bidir_line_three_oe_n_o, bidir_line_two_oe_n_o,
                 bidir_line_one_oe_n_o, bidir_line_zero_oe_n_o};
  assign lk = status_lock_lower_bit_i && !status_lock_upper_bit_i;
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  float_desel_a: assert property (spi_cs_n_i [*4] |-> &oe_n)
    else $error("line driven while deselected");
  standby_set_a: assert property ((spi_cs_n_i && !busy_i) [*4] |-> standby_o)
    else $error("standby missing");
  frame_mark_a: assert property ($fell(spi_cs_n_i) |-> ##[2:4] frame_start_o)
    else $error("frame start missing");
  take_pulse_a: assert property (tx_take_o |=> !tx_take_o)
    else $error("take pulse too long");
  idle_float_a: assert property (!data_out_phase_i [*4] |-> &oe_n)
    else $error("line driven outside read phase");
  quad_refuse_a: assert property (quad_refused_o ==
    (width_i == sfpi_w_quad && !quad_enable_bit_i))
    else $error("quad refusal wrong");
  lock_cause_a: assert property (status_write_blocked_o |-> lk && !quad_enable_bit_i)
    else $error("lock without cause");
  lock_set_a: assert property ((!bidir_line_two_i && lk && !quad_enable_bit_i) [*4] |-> status_write_blocked_o)
    else $error("lock missing");
  lock_same_a: assert property (array_protect_locked_o == status_write_blocked_o)
    else $error("array lock differs");
  pause_float_a: assert property (paused_o |-> &oe_n)
    else $error("line driven while paused");
  pause_sel_a: assert property (spi_cs_n_i [*4] |-> !paused_o)
    else $error("pause without select");
  pause_quad_a: assert property (quad_enable_bit_i [*4] |-> !paused_o)
    else $error("pause with quad enable");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o)
    else $error("byte lost before pop");
endmodule : sfpi_chk

bind sfpi_top sfpi_chk i_chk (.ref_clk_i, .rst_n_i, .spi_cs_n_i,
  .bidir_line_two_i, .bidir_line_zero_oe_n_o, .bidir_line_one_oe_n_o,
  .bidir_line_two_oe_n_o, .bidir_line_three_oe_n_o, .width_i,
  .data_out_phase_i, .busy_i, .status_lock_upper_bit_i,
  .status_lock_lower_bit_i, .quad_enable_bit_i, .rx_valid_o, .rx_ready_i,
  .tx_take_o, .standby_o, .frame_start_o, .paused_o, .quad_refused_o,
  .status_write_blocked_o, .array_protect_locked_o);

/* File: bench/tb.sv */
// Purpose: self-checking bench of the pin front end
// Assumes: host model drives the link, bench drives the core side
// Notes:   table rows first, then reset, read, pause, fifo cases
`timescale 1ns/10ps
module tb;
  import sfpi_pkg::*;
  // row: width, {qe,upper,lower,wp_n,busy}, byte, {refused,lock}
  typedef struct packed {
    sfpi_width_type w;
    logic [4:0]     c;
    logic [7:0]     b;
    logic [1:0]     e;
  } sfpi_row_type;
  sfpi_row_type rows [7] = '{
    {sfpi_w_single, 5'h02, 8'hA5, 2'h0}, {sfpi_w_dual, 5'h02, 8'h3C, 2'h0},
    {sfpi_w_quad, 5'h12, 8'h96, 2'h0}, {sfpi_w_quad, 5'h02, 8'h5A, 2'h2},
    {sfpi_w_single, 5'h04, 8'h0F, 2'h1}, {sfpi_w_single, 5'h0D, 8'hF0, 2'h0},
    {sfpi_w_dual, 5'h14, 8'h81, 2'h0}};
  logic ref_clk_i, rst_n_i, phase, busy, up, lo, qe, rx_ready;
  logic idle_pat = 1'b0; // level of floating lines zero and one
  sfpi_width_type  width;        // width asked by the core
  logic [7:0]      tx_data, r;   // read byte, host result
  logic [3:0]      line, dev_o, dev_oe_n, hd, hoe_n;
  wire logic       spi_clk, cs_n; // host pins
  logic [7:0]      rx_data_o;
  logic rx_valid_o, tx_take_o, selected_o, standby_o, paused_o, rx_overrun_o;
  logic quad_refused_o, status_write_blocked_o, array_protect_locked_o;
  int n_mismatch = 0, tests_run = 0, n_take = 0, nl, take_base;

  // reference clock, 8 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // floating lines toggle; pull-ups on two and three
  always @(posedge ref_clk_i) idle_pat <= ~idle_pat;
  always @(posedge ref_clk_i) if (tx_take_o === 1'b1) n_take++;
  always_comb begin
    for (int k = 0; k < 4; k++)
      line[k] = !dev_oe_n[k] ? dev_o[k] : !hoe_n[k] ? hd[k] : k > 1 ? 1'b1 : idle_pat;
  end

  sfpi_host i_host (.spi_clk_o(spi_clk), .spi_cs_n_o(cs_n), .dat_o(hd),
                    .dat_oe_n_o(hoe_n), .line_i(line));
  sfpi_top i_dut (.ref_clk_i, .rst_n_i, .spi_clk_i(spi_clk), .spi_cs_n_i(cs_n),
    .bidir_line_zero_i(line[0]), .bidir_line_zero_o(dev_o[0]), .bidir_line_zero_oe_n_o(dev_oe_n[0]),
    .bidir_line_one_i(line[1]), .bidir_line_one_o(dev_o[1]), .bidir_line_one_oe_n_o(dev_oe_n[1]),
    .bidir_line_two_i(line[2]), .bidir_line_two_o(dev_o[2]), .bidir_line_two_oe_n_o(dev_oe_n[2]),
    .bidir_line_three_i(line[3]), .bidir_line_three_o(dev_o[3]), .bidir_line_three_oe_n_o(dev_oe_n[3]),
    .width_i(width), .data_out_phase_i(phase), .busy_i(busy),
    .status_lock_upper_bit_i(up), .status_lock_lower_bit_i(lo), .quad_enable_bit_i(qe),
    .rx_data_o, .rx_valid_o, .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_take_o,
    .selected_o, .standby_o, .frame_start_o(), .paused_o, .quad_refused_o,
    .rx_overrun_o, .status_write_blocked_o, .array_protect_locked_o);

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  // take the head byte from the fifo
  task automatic pop_check(input logic [7:0] e);
    chk_bit("rx_valid", 1'b1, rx_valid_o);
    chk_byte("rx_data", e, rx_data_o);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask : pop_check
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // watchdog, about ten times the expected run
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial begin
    {rst_n_i, phase, busy, up, lo, qe, rx_ready} = 7'h00;
    width = sfpi_w_single;
    tx_data = 8'h00;
    tick(20);
    rst_n_i = 1'b1;
    tick(3);
    foreach (rows[n]) begin
      width = rows[n].w;
      {qe, up, lo, i_host.wp_n, busy} = rows[n].c;
      i_host.rel();
      nl = width == sfpi_w_dual ? 2 : width == sfpi_w_quad && qe ? 4 : 1;
      i_host.frame_begin();
      i_host.xfer(nl, 0, rows[n].b, r);
      tick(6);
      chk_bit("refused", rows[n].e[1], quad_refused_o);
      chk_bit("lock", rows[n].e[0], status_write_blocked_o);
      chk_bit("array_lock", rows[n].e[0], array_protect_locked_o);
      i_host.frame_end();
      tick(6);
      chk_bit("standby", !busy, standby_o);
      pop_check(rows[n].b);
      $display("row %0d done", n);
    end
    {qe, up, lo, i_host.wp_n, busy} = 5'h02;
    i_host.rel();
    width = sfpi_w_single;
    // select held low across reset: no fall seen, so not armed
    i_host.frame_begin();
    rst_n_i = 1'b0;
    tick(20);
    rst_n_i = 1'b1;
    tick(3);
    chk_byte("oe_n", 8'h0F, 8'(dev_oe_n));
    chk_bit("selected", 1'b0, selected_o);
    i_host.xfer(1, 0, 8'hC3, r);
    tick(8);
    chk_bit("rx_valid", 1'b0, rx_valid_o);
    i_host.frame_end();
    i_host.xfer(1, 0, 8'h5A, r);
    tick(8);
    chk_bit("rx_valid", 1'b0, rx_valid_o);
    $display("reset test done");
    for (int m = 0; m < 2; m++) begin
      width = m ? sfpi_w_quad : sfpi_w_single;
      qe = m[0];
      i_host.cpol = m[0];
      tx_data = m ? 8'h5A : 8'hA5;
      take_base = n_take;
      i_host.frame_begin();
      i_host.xfer(m ? 4 : 1, 0, 8'h0B, r);
      tick(1);
      phase = 1'b1;
      i_host.xfer(m ? 4 : 1, 1, 8'h00, r);
      chk_byte("read", tx_data, r);
      chk_byte("take", 8'h01, 8'(n_take - take_base));
      i_host.frame_end();
      tick(1);
      phase = 1'b0;
      pop_check(8'h0B);
      $display("read test %0d done", m);
    end
    width = sfpi_w_single;
    qe = 1'b0;
    i_host.cpol = 1'b0;
    i_host.frame_begin();
    i_host.set_hold(1'b0);
    tick(8);
    chk_bit("paused", 1'b1, paused_o);
    i_host.xfer(1, 0, 8'hFF, r);
    chk_bit("rx_valid", 1'b0, rx_valid_o);
    i_host.set_hold(1'b1);
    i_host.xfer(1, 0, 8'h3C, r);
    i_host.frame_end();
    tick(6);
    chk_bit("paused", 1'b0, paused_o);
    pop_check(8'h3C);
    chk_bit("rx_valid", 1'b0, rx_valid_o);
    $display("pause test done");
    i_host.frame_begin();
    for (int k = 0; k < 9; k++)
      i_host.xfer(1, 0, 8'(k * 17), r);
    i_host.frame_end();
    tick(6);
    chk_bit("overrun", 1'b1, rx_overrun_o);
    for (int k = 0; k < 8; k++)
      pop_check(8'(k * 17));
    chk_bit("rx_valid", 1'b0, rx_valid_o);
    $display("fifo test done");
    test_done();
  end
endmodule : tb
